// ---- rtl/secp_device.sv ----
`include "secp_map.svh"
`default_nettype none
module secp_device #(
	parameter int PROG_CYCLES = `SECP_T_PROG_MS * `SECP_CLK_MHZ * 1000 // Self-timed cycle length in clocks.
) (
	// Clock, enable and reset.
	input  wire logic CLOCK_I,
	input  wire logic CE_I,
	input  wire logic RST_I,
	// Serial link toward the host.
	secp_if.device    LINK,
	// Status for the surrounding logic.
	output logic      BUSY_O,
	output logic      PROG_EN_O
);
	secp_pkg::secp_dev_s s;      // Registered state, memory included.
	secp_pkg::secp_dev_s next_s; // Next state.

	logic [2:0] pin_lvl;  // Synchronised select, clock and data in.
	logic [2:0] pin_rise; // Rising edges of the same pins.
	logic [2:0] pin_fall; // Falling edges of the same pins.
	logic       sel;      // Device selected.
	logic       sel_fall; // Select has just dropped.
	logic       sk_rise;  // Serial clock has just risen.
	logic       di;       // Data in as it stood at the clock rise.

	// Timer load for the self-timed cycle, one less than its length.
	localparam secp_pkg::secp_prog_t PROG_LOAD = secp_pkg::secp_prog_t'(PROG_CYCLES - 1);

	// All three pins come from the host and cross into this clock.
	// Data in passes the same two stages as the serial clock, so the level
	// read at a detected rise is the one the host set up before it.
	secp_sync_edge #(
		.W(3)
	) u_sync (
		.clk_i  (CLOCK_I),
		.ce_i   (CE_I),
		.rst_i  (RST_I),
		.pin_i  ({LINK.select_line, LINK.serial_clock, LINK.serial_in}),
		.level_o(pin_lvl),
		.rise_o (pin_rise),
		.fall_o (pin_fall)
	);

	// Name the synchronised pins by use.
	assign sel      = pin_lvl[2];
	assign sel_fall = pin_fall[2];
	assign sk_rise  = pin_rise[1];
	assign di       = pin_lvl[0];

	// Decode, shift and program; one process builds the next state.
	always_comb begin
		logic [`SECP_CMD_W-1:0]  word;
		logic [`SECP_ADDR_W-1:0] addr;
		logic [1:0]              op;
		logic [1:0]              sub;
		word   = {s.cmd[6:0], di};
		addr   = s.cmd[5:0];
		op     = s.cmd[7:6];
		sub    = s.cmd[5:4];
		next_s = s;
		unique case (s.st)
			// Wait for a start bit while selected.
			secp_pkg::DEV_IDLE: begin
				if (sel && sk_rise && (di == `SECP_START_BIT)) begin
					next_s.st  = secp_pkg::DEV_CMD;
					next_s.cnt = '0;
				end
			end
			// Collect op code and address, then decode.
			secp_pkg::DEV_CMD: begin
				if (!sel) begin
					next_s.st = secp_pkg::DEV_IDLE;
				end else if (sk_rise) begin
					next_s.cmd = word;
					next_s.cnt = s.cnt + 5'h01;
					if (s.cnt == `SECP_CMD_LAST) begin
						next_s.cnt = '0;
						if (word[7:6] == `SECP_OP_READ) begin
							// Read works whatever the enable state is.
							next_s.shreg = s.mem[word[5:0]];
							next_s.dout  = `SECP_DUMMY_BIT;
							next_s.st    = secp_pkg::DEV_READ;
						end else if ((word[7:6] == `SECP_OP_SPECIAL) && (word[5:4] == `SECP_SUB_EN)) begin
							next_s.en = 1'b1;
							next_s.st = secp_pkg::DEV_IDLE;
						end else if ((word[7:6] == `SECP_OP_SPECIAL) && (word[5:4] == `SECP_SUB_DIS)) begin
							next_s.en = 1'b0;
							next_s.st = secp_pkg::DEV_IDLE;
						end else if (secp_pkg::secp_has_data(word)) begin
							next_s.st = secp_pkg::DEV_DATA;
						end else begin
							// Erase instructions are dropped while disabled.
							next_s.st = s.en ? secp_pkg::DEV_ARMED : secp_pkg::DEV_IDLE;
						end
					end
				end
			end
			// Collect the sixteen data bits of a write.
			secp_pkg::DEV_DATA: begin
				if (!sel) begin
					next_s.st = secp_pkg::DEV_IDLE;
				end else if (sk_rise) begin
					next_s.data = {s.data[14:0], di};
					next_s.cnt  = s.cnt + 5'h01;
					if (s.cnt == `SECP_DATA_LAST) begin
						// No erase is needed first; disabled writes are dropped.
						next_s.st = s.en ? secp_pkg::DEV_ARMED : secp_pkg::DEV_IDLE;
					end
				end
			end
			// Shift the read word out, one bit per clock rise.
			// Clocks beyond the sixteenth data bit shift out zeros.
			secp_pkg::DEV_READ: begin
				if (!sel) begin
					next_s.st = secp_pkg::DEV_IDLE;
				end else if (sk_rise) begin
					next_s.dout  = s.shreg[15];
					next_s.shreg = {s.shreg[14:0], 1'b0};
				end
			end
			// Wait for select to drop; an extra clock rise cancels.
			// A host that clocks past the last bit has lost count of the frame,
			// so nothing is written rather than a shifted word.
			secp_pkg::DEV_ARMED: begin
				if (sel_fall) begin
					next_s.st    = secp_pkg::DEV_PROG;
					next_s.timer = PROG_LOAD;
					next_s.dout  = `SECP_STAT_BUSY;
					if (op == `SECP_OP_ERASE) begin
						next_s.mem[addr] = `SECP_ERASED;
					end else if (op == `SECP_OP_WRITE) begin
						next_s.mem[addr] = s.data;
					end else begin
						// Both whole-array instructions complete in one cycle.
						for (int i = 0; i < `SECP_WORDS; i++) begin
							next_s.mem[i] = (sub == `SECP_SUB_ERASE_ALL_CMD) ? `SECP_ERASED : s.data;
						end
					end
				end else if (sk_rise) begin
					next_s.st = secp_pkg::DEV_IDLE;
				end
			end
			// Self-timed cycle; the link is ignored meanwhile.
			// The array was updated when the cycle began; the timer only paces
			// the busy status, so a read after ready always sees the new word.
			secp_pkg::DEV_PROG: begin
				next_s.timer = s.timer - secp_pkg::secp_prog_t'(1);
				if (s.timer == '0) begin
					next_s.st   = secp_pkg::DEV_READY;
					next_s.dout = `SECP_STAT_READY;
				end
			end
			// Show ready until deselected or a new start bit comes.
			secp_pkg::DEV_READY: begin
				if (sel_fall) begin
					next_s.st = secp_pkg::DEV_IDLE;
				end else if (sel && sk_rise && (di == `SECP_START_BIT)) begin
					next_s.st  = secp_pkg::DEV_CMD;
					next_s.cnt = '0;
				end
			end
		endcase
	end

	// Register the state; reset stands for power-up, so programming is off.
	// The array comes up erased because there is no retained content to model.
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			s     <= '0;
			s.mem <= {`SECP_WORDS{`SECP_ERASED}};
		end else if (CE_I) begin
			s <= next_s;
		end
	end

	// Drive the output only while selected in a reporting state.
	// The data flip-flop keeps its last value when released; the host must
	// qualify it with the output enable, as a released pin carries no level.
	assign LINK.serial_out    = s.dout;
	assign LINK.serial_out_oe = sel && ((s.st == secp_pkg::DEV_READ) || (s.st == secp_pkg::DEV_PROG) ||
		(s.st == secp_pkg::DEV_READY));

	// Status toward the surrounding logic.
	assign BUSY_O    = (s.st == secp_pkg::DEV_PROG);
	assign PROG_EN_O = s.en;
endmodule
`default_nettype wire

// ---- rtl/secp_map.svh ----
`ifndef SECP_MAP_SVH
`define SECP_MAP_SVH

// Word, address and instruction geometry.
`define SECP_WORD_W     16
`define SECP_ADDR_W     6
`define SECP_CMD_W      8
`define SECP_WORDS      64
`define SECP_FRAME_W    25

// Op codes in the two bits after the start bit.
`define SECP_OP_SPECIAL 2'h0
`define SECP_OP_WRITE   2'h1
`define SECP_OP_READ    2'h2
`define SECP_OP_ERASE   2'h3

// Special instructions, selected by the two upper address bits.
`define SECP_SUB_DIS    2'h0
`define SECP_SUB_WRITE_ALL_CMD   2'h1
`define SECP_SUB_ERASE_ALL_CMD   2'h2
`define SECP_SUB_EN     2'h3

// Fixed bit values on the wires.
`define SECP_START_BIT  1'h1
`define SECP_DUMMY_BIT  1'h0
`define SECP_STAT_BUSY  1'h0
`define SECP_STAT_READY 1'h1
`define SECP_ERASED     16'hffff

// Last bit index of each field and of each frame length.
`define SECP_CMD_LAST   5'h07
`define SECP_DATA_LAST  5'h0f
`define SECP_SHORT_LAST 5'h08
`define SECP_LONG_LAST  5'h18

// Times in their own units and the clock rate.
`define SECP_CLK_MHZ    100
`define SECP_T_PROG_MS  10
`define SECP_T_CS_NS    500
`define SECP_T_SKH_NS   500

// Least times rounded up to whole clock cycles.
`define SECP_CS_CYC     ((`SECP_T_CS_NS * `SECP_CLK_MHZ + 999) / 1000)
`define SECP_SKH_CYC    ((`SECP_T_SKH_NS * `SECP_CLK_MHZ + 999) / 1000)

// Timer widths.
`define SECP_TMR_W      8
`define SECP_PROG_W     24

`endif

// ---- rtl/secp_pkg.sv ----
`include "secp_map.svh"
`default_nettype none
package secp_pkg;
	// Timer types for the host pacing and the self-timed cycle.
	typedef logic [`SECP_TMR_W-1:0]  secp_tmr_t;
	typedef logic [`SECP_PROG_W-1:0] secp_prog_t;

	// Device states.
	typedef enum logic [2:0] {DEV_IDLE, DEV_CMD, DEV_DATA, DEV_READ, DEV_ARMED, DEV_PROG, DEV_READY} secp_dev_e;

	// Host states.
	typedef enum logic [2:0] {HOST_IDLE, HOST_SETUP, HOST_LOW, HOST_HIGH, HOST_GAP, HOST_POLL, HOST_END} secp_host_e;

	// Whole state of the device end, the memory array included.
	typedef struct packed {
		secp_dev_e                                  st;
		logic                                       en;
		logic [4:0]                                 cnt;
		logic [`SECP_CMD_W-1:0]                     cmd;
		logic [`SECP_WORD_W-1:0]                    data;
		logic [`SECP_WORD_W-1:0]                    shreg;
		logic                                       dout;
		secp_prog_t                                 timer;
		logic [`SECP_WORDS-1:0][`SECP_WORD_W-1:0]   mem;
	} secp_dev_s;

	// Whole state of the host end.
	typedef struct packed {
		secp_host_e                st;
		secp_tmr_t                 tmr;
		logic [4:0]                bitn;
		logic [4:0]                last;
		logic [`SECP_FRAME_W-1:0]  sh;
		logic [`SECP_WORD_W-1:0]   rx;
		logic                      sk;
		logic                      sel;
		logic                      di;
		logic                      en;
		logic                      prog;
		logic                      done;
		logic                      err;
	} secp_host_s;

	// True for instructions that start a self-timed programming cycle.
	function automatic logic secp_is_prog(input logic [`SECP_CMD_W-1:0] cmd);
		logic [1:0] op;
		logic [1:0] sub;
		op  = cmd[7:6];
		sub = cmd[5:4];
		return (op == `SECP_OP_WRITE) || (op == `SECP_OP_ERASE) ||
			((op == `SECP_OP_SPECIAL) && ((sub == `SECP_SUB_ERASE_ALL_CMD) || (sub == `SECP_SUB_WRITE_ALL_CMD)));
	endfunction

	// True for instructions followed by a 16-bit data word.
	function automatic logic secp_has_data(input logic [`SECP_CMD_W-1:0] cmd);
		return (cmd[7:6] == `SECP_OP_WRITE) ||
			((cmd[7:6] == `SECP_OP_SPECIAL) && (cmd[5:4] == `SECP_SUB_WRITE_ALL_CMD));
	endfunction
endpackage
`default_nettype wire

// ---- rtl/secp_if.sv ----
`default_nettype none
interface secp_if;
	logic select_line;   // Host selects the device, active high.
	logic serial_clock;  // Serial clock made by the host.
	logic serial_in;     // Instruction and data bits toward the device.
	logic serial_out;    // Read data or busy and ready status from the device.
	logic serial_out_oe; // High while the device drives serial_out.

	// The documented device end.
	modport device (
		input  select_line,
		input  serial_clock,
		input  serial_in,
		output serial_out,
		output serial_out_oe
	);

	// The controlling host end.
	modport host (
		output select_line,
		output serial_clock,
		output serial_in,
		input  serial_out,
		input  serial_out_oe
	);
endinterface
`default_nettype wire

// ---- rtl/secp_sync_edge.sv ----
`default_nettype none
module secp_sync_edge #(
	parameter int W = 1 // Number of pins synchronised.
) (
	// Clock, enable and reset.
	input  wire logic         clk_i,
	input  wire logic         ce_i,
	input  wire logic         rst_i,
	// Pins from another clock domain.
	input  wire logic [W-1:0] pin_i,
	// Synchronised level and its edges.
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	// The first stage is read only by the second one.
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] lvl;
		logic [W-1:0] prev;
	} secp_sync_s;

	secp_sync_s s;      // Registered state.
	secp_sync_s next_s; // Next state.

	// Shift the pins through two stages and keep one more for edges.
	always_comb begin
		next_s      = s;
		next_s.meta = pin_i;
		next_s.lvl  = s.meta;
		next_s.prev = s.lvl;
	end

	// Register the state; a low enable freezes it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// Edges come from the settled stages only.
	assign level_o = s.lvl;
	assign rise_o  = s.lvl & ~s.prev;
	assign fall_o  = ~s.lvl & s.prev;
endmodule
`default_nettype wire

// ---- rtl/secp_host.sv ----
`include "secp_map.svh"
`default_nettype none
module secp_host (
	// Clock, enable and reset.
	input  wire logic                     CLOCK_I,
	input  wire logic                     CE_I,
	input  wire logic                     RST_I,
	// Serial link toward the device.
	secp_if.host                          LINK,
	// Command request from the user.
	input  wire logic                     CMD_VALID_I,
	output logic                          CMD_READY_O,
	input  wire logic [1:0]               CMD_OP_I,
	input  wire logic [`SECP_ADDR_W-1:0]  CMD_ADDR_I,
	input  wire logic [`SECP_WORD_W-1:0]  CMD_DATA_I,
	// Completion toward the user.
	output logic                          DONE_O,
	output logic                          ERR_O,
	output logic [`SECP_WORD_W-1:0]       RD_DATA_O
);
	secp_pkg::secp_host_s s;      // Registered state.
	secp_pkg::secp_host_s next_s; // Next state.

	logic [1:0] out_lvl; // Synchronised output enable and data out.
	logic       tmr_zero; // Pacing timer has run out.
	logic       ready_seen; // Device drives the ready level.

	// Loads for the half clock period and the select low time.
	localparam secp_pkg::secp_tmr_t HALF_LOAD = secp_pkg::secp_tmr_t'(`SECP_SKH_CYC - 1);
	localparam secp_pkg::secp_tmr_t CS_LOAD   = secp_pkg::secp_tmr_t'(`SECP_CS_CYC - 1);

	// The device answer comes from outside this clock.
	secp_sync_edge #(
		.W(2)
	) u_sync (
		.clk_i  (CLOCK_I),
		.ce_i   (CE_I),
		.rst_i  (RST_I),
		.pin_i  ({LINK.serial_out_oe, LINK.serial_out}),
		.level_o(out_lvl),
		.rise_o (),
		.fall_o ()
	);

	assign tmr_zero   = (s.tmr == '0);
	assign ready_seen = out_lvl[1] && (out_lvl[0] == `SECP_STAT_READY);

	// Build frames, pace the serial clock and poll for ready.
	always_comb begin
		logic [`SECP_CMD_W-1:0] cmd;
		cmd         = {CMD_OP_I, CMD_ADDR_I};
		next_s      = s;
		next_s.tmr  = tmr_zero ? s.tmr : s.tmr - secp_pkg::secp_tmr_t'(1);
		next_s.done = 1'b0;
		next_s.err  = 1'b0;
		unique case (s.st)
			// Accept a command; programming without enable is refused.
			secp_pkg::HOST_IDLE: begin
				if (CMD_VALID_I) begin
					if (secp_pkg::secp_is_prog(cmd) && !s.en) begin
						next_s.done = 1'b1;
						next_s.err  = 1'b1;
					end else begin
						if (CMD_OP_I == `SECP_OP_SPECIAL && CMD_ADDR_I[5:4] == `SECP_SUB_EN) begin
							next_s.en = 1'b1;
						end else if (CMD_OP_I == `SECP_OP_SPECIAL && CMD_ADDR_I[5:4] == `SECP_SUB_DIS) begin
							next_s.en = 1'b0;
						end
						next_s.sh   = {`SECP_START_BIT, cmd, CMD_DATA_I};
						next_s.last = (secp_pkg::secp_has_data(cmd) || CMD_OP_I == `SECP_OP_READ) ?
							`SECP_LONG_LAST : `SECP_SHORT_LAST;
						next_s.prog = secp_pkg::secp_is_prog(cmd);
						next_s.bitn = '0;
						next_s.sel  = 1'b1;
						next_s.tmr  = HALF_LOAD;
						next_s.st   = secp_pkg::HOST_SETUP;
					end
				end
			end
			// Select setup before the first bit.
			secp_pkg::HOST_SETUP: begin
				if (tmr_zero) begin
					next_s.di  = s.sh[`SECP_FRAME_W-1];
					next_s.tmr = HALF_LOAD;
					next_s.st  = secp_pkg::HOST_LOW;
				end
			end
			// Clock low half with data set up.
			secp_pkg::HOST_LOW: begin
				if (tmr_zero) begin
					next_s.sk  = 1'b1;
					next_s.tmr = HALF_LOAD;
					next_s.st  = secp_pkg::HOST_HIGH;
				end
			end
			// Clock high half; sample the answer at its end.
			secp_pkg::HOST_HIGH: begin
				if (tmr_zero) begin
					next_s.sk   = 1'b0;
					next_s.rx   = {s.rx[14:0], out_lvl[0]};
					next_s.sh   = {s.sh[`SECP_FRAME_W-2:0], 1'b0};
					next_s.bitn = s.bitn + 5'h01;
					next_s.tmr  = HALF_LOAD;
					if (s.bitn == s.last) begin
						// Select drops before any further clock rise.
						next_s.sel = 1'b0;
						next_s.tmr = CS_LOAD;
						next_s.st  = s.prog ? secp_pkg::HOST_GAP : secp_pkg::HOST_END;
					end else begin
						next_s.di = s.sh[`SECP_FRAME_W-2];
						next_s.st = secp_pkg::HOST_LOW;
					end
				end
			end
			// Hold select low its least time, then raise it for status.
			secp_pkg::HOST_GAP: begin
				if (tmr_zero) begin
					next_s.sel = 1'b1;
					next_s.st  = secp_pkg::HOST_POLL;
				end
			end
			// Wait for the ready level.
			secp_pkg::HOST_POLL: begin
				if (ready_seen) begin
					next_s.sel = 1'b0;
					next_s.tmr = CS_LOAD;
					next_s.st  = secp_pkg::HOST_END;
				end
			end
			// Close with select low its least time.
			secp_pkg::HOST_END: begin
				if (tmr_zero) begin
					next_s.done = 1'b1;
					next_s.st   = secp_pkg::HOST_IDLE;
				end
			end
		endcase
	end

	// Register the state; a low enable freezes it.
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			s <= '0;
		end else if (CE_I) begin
			s <= next_s;
		end
	end

	// Link pins and user outputs.
	assign LINK.select_line  = s.sel;
	assign LINK.serial_clock = s.sk;
	assign LINK.serial_in    = s.di;
	assign CMD_READY_O       = (s.st == secp_pkg::HOST_IDLE);
	assign DONE_O            = s.done;
	assign ERR_O             = s.err;
	assign RD_DATA_O         = s.rx;
endmodule
`default_nettype wire

// ---- test/secp_chk.sv ----
`default_nettype none
module secp_chk (
	// Clock and reset.
	input  wire logic CLOCK_I,
	input  wire logic RST_I,
	// Link signals as seen on the wires.
	input  wire logic select_line,
	input  wire logic serial_clock,
	input  wire logic serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       sk_d;  // Serial clock one cycle ago.
	logic       sel_d; // Select one cycle ago.
	logic [4:0] cnt;   // Serial clock rises in this frame, saturating.
	logic [8:0] hdr;   // Start bit, op code and address of this frame.
	logic [3:0] age;   // Cycles since the last serial clock rise.
	logic       armed; // The last frame started a self-timed cycle.
	logic [1:0] op;    // Op code of this frame.
	logic       short_op; // Frame ends after the address.
	logic       long_op;  // Frame carries a data word.

	assign op       = hdr[7:6];
	assign short_op = (op == 2'h3) || ((op == 2'h0) && (hdr[5:4] != 2'h1));
	assign long_op  = (op == 2'h1) || ((op == 2'h0) && (hdr[5:4] == 2'h1));

	// Tracks the frame on the wire so the properties know what was sent.
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			sk_d  <= 1'b0;
			sel_d <= 1'b0;
			cnt   <= 5'h00;
			hdr   <= 9'h000;
			age   <= 4'hf;
			armed <= 1'b0;
		end else begin
			sk_d  <= serial_clock;
			sel_d <= select_line;
			age   <= (serial_clock && !sk_d) ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
			// A falling select decides whether a programming cycle was launched.
			if (sel_d && !select_line) begin
				armed <= (cnt == 5'd9 && short_op && op != 2'h0) || (cnt == 5'd9 && op == 2'h0 && hdr[5:4] == 2'h2)
					|| (cnt == 5'd25 && long_op);
			end
			if (!select_line) begin
				cnt <= 5'h00;
				hdr <= 9'h000;
			end else if (serial_clock && !sk_d) begin
				cnt <= (cnt == 5'h1f) ? cnt : cnt + 5'h01;
				if (cnt < 5'd9) begin
					hdr <= {hdr[7:0], serial_in};
				end
			end
		end
	end

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);

	property p_start_bit;
		select_line && $rose(serial_clock) && cnt == 5'd0 |-> serial_in;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("first bit of frame is not one");

	property p_short_frame;
		select_line && cnt == 5'd9 && short_op |-> !$rose(serial_clock);
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("clock after address of short frame");

	property p_long_frame;
		select_line && cnt == 5'd25 && long_op |-> !$rose(serial_clock);
	endproperty
	a_long_frame: assert property (p_long_frame) else $error("clock after last data bit");

	property p_release;
		(!select_line) [*5] |-> !serial_out_oe;
	endproperty
	a_release: assert property (p_release) else $error("output driven while deselected");

	property p_dummy;
		$rose(serial_out_oe) && cnt == 5'd9 && op == 2'h2 |-> !serial_out;
	endproperty
	a_dummy: assert property (p_dummy) else $error("read does not open with zero");

	property p_read_edge;
		select_line && serial_out_oe && $past(serial_out_oe) && cnt != 5'd0 && $changed(serial_out)
			|-> age inside {[4'h1:4'h6]};
	endproperty
	a_read_edge: assert property (p_read_edge) else $error("read data moved without clock rise");

	property p_status_up;
		armed && $rose(select_line) |-> ##[1:8] serial_out_oe;
	endproperty
	a_status_up: assert property (p_status_up) else $error("no status after programming");

	property p_status_hold;
		armed && select_line && serial_out_oe && serial_out |=> serial_out_oe && serial_out;
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("ready status dropped");

	// Main scenarios reached.
	c_read: cover property ($rose(serial_out_oe) && cnt == 5'd9 && op == 2'h2);
	c_long: cover property (select_line && cnt == 5'd25 && long_op);
	c_ready: cover property (armed && serial_out_oe && serial_out);
endmodule
`default_nettype wire

// ---- test/tb_serial_eeprom_command_port.sv ----
`default_nettype none
module tb_serial_eeprom_command_port;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int PROG_CYC = 200; // Self-timed cycle longer than the select gap, so busy is seen first.

	logic        clk;       // Bench clock.
	logic        rst;       // Synchronous reset.
	logic        cmd_valid; // Request toward the host end.
	logic        cmd_ready; // Host end is idle.
	logic [1:0]  cmd_op;    // Requested op code.
	logic [5:0]  cmd_addr;  // Requested address or sub code.
	logic [15:0] cmd_data;  // Requested write data.
	logic        done;      // Completion pulse.
	logic        err;       // Refusal flag with completion.
	logic [15:0] rd_data;   // Word read back.
	logic        busy;      // Device self-timed cycle running.
	logic        prog_en;   // Device programming enabled.
	int          mismatches;
	int          compares;
	logic [15:0] mem [64];  // Reference copy of the array.
	logic        en;        // Reference programming enable.
	logic [5:0]  adr [4];   // Addresses exercised, edges included.
	logic [15:0] d;         // Scratch data.

	secp_if link ();

	secp_device #(.PROG_CYCLES(PROG_CYC)) secp_device_i (.CLOCK_I(clk), .CE_I(1'b1), .RST_I(rst),
		.LINK(link), .BUSY_O(busy), .PROG_EN_O(prog_en));
	secp_host secp_host_i (.CLOCK_I(clk), .CE_I(1'b1), .RST_I(rst), .LINK(link), .CMD_VALID_I(cmd_valid),
		.CMD_READY_O(cmd_ready), .CMD_OP_I(cmd_op), .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data),
		.DONE_O(done), .ERR_O(err), .RD_DATA_O(rd_data));
	secp_chk secp_chk_i (.CLOCK_I(clk), .RST_I(rst), .select_line(link.select_line),
		.serial_clock(link.serial_clock), .serial_in(link.serial_in), .serial_out(link.serial_out),
		.serial_out_oe(link.serial_out_oe));

	// Free running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Runs one instruction through the host and checks it against the reference.
	task automatic cmd(input logic [1:0] op, input logic [5:0] ad, input logic [15:0] dt);
		int          n;
		logic        pr;
		logic        xerr;
		logic [15:0] xrd;
		logic        rdy;  // Ready level just after the request was taken.
		logic        stat; // Busy level was seen on the wire during the cycle.
		pr   = (op == 2'h1) || (op == 2'h3) || (op == 2'h0 && (ad[5:4] == 2'h1 || ad[5:4] == 2'h2));
		xerr = pr && !en;
		xrd  = mem[ad];
		rdy  = 1'b0;
		stat = 1'b0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_addr  <= ad;
		cmd_data  <= dt;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		// Completion is looked at on the falling edge, where it is settled.
		do begin
			@(negedge clk);
			n++;
			if (n == 1)
				rdy = cmd_ready;
			// Busy status shows only while the self-timed cycle runs.
			if (busy && link.serial_out_oe && link.serial_out === 1'b0)
				stat = 1'b1;
		end while (done !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			mismatches++;
			results();
		end
		chk({15'h0, err}, {15'h0, xerr}, "refusal flag");
		chk({15'h0, rdy}, {15'h0, xerr}, "ready after take");
		chk({15'h0, stat}, {15'h0, pr && !xerr}, "busy status on the wire");
		if (op == 2'h2)
			chk(rd_data, xrd, "read word");
		// Reference update follows the decoded instruction.
		if (!xerr) begin
			case (op)
				2'h1: mem[ad] = dt;
				2'h3: mem[ad] = 16'hffff;
				2'h0: begin
					case (ad[5:4])
						2'h0: en = 1'b0;
						2'h1: foreach (mem[i]) mem[i] = dt;
						2'h2: foreach (mem[i]) mem[i] = 16'hffff;
						default: en = 1'b1;
					endcase
				end
				default: ;
			endcase
		end
	endtask

	// Cuts a hang short.
	initial begin
		// The full sequence needs about 58,000 cycles; allow half as much again.
		#(90000 * 10);
		mismatches++;
		results();
	end

	// Main sequence.
	initial begin
		rst        = 1'b1;
		cmd_valid  = 1'b0;
		cmd_op     = 2'h0;
		cmd_addr   = 6'h00;
		cmd_data   = 16'h0000;
		mismatches = 0;
		compares   = 0;
		en         = 1'b0;
		foreach (mem[i]) mem[i] = 16'hffff;
		adr = '{6'h00, 6'h3f, 6'h15, 6'h2a};
		void'($urandom(32'h04c29e5a));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({15'h0, prog_en}, 16'h0000, "enable after reset");
		cmd(2'h1, 6'h05, 16'h1234);
		cmd(2'h2, 6'h05, 16'h0000);
		cmd(2'h0, {2'h3, 4'($urandom)}, 16'h0000);
		chk({15'h0, prog_en}, 16'h0001, "enable set");
		// Writes and read back at both ends of the array and inside it.
		for (int i = 0; i < 4; i++) begin
			d = 16'($urandom);
			cmd(2'h1, adr[i], d);
			cmd(2'h2, adr[i], 16'h0000);
		end
		cmd(2'h2, adr[0], 16'h0000);
		cmd(2'h3, adr[1], 16'h0000);
		cmd(2'h2, adr[1], 16'h0000);
		cmd(2'h2, adr[2], 16'h0000);
		cmd(2'h0, {2'h1, 4'($urandom)}, 16'($urandom));
		cmd(2'h2, 6'($urandom), 16'h0000);
		cmd(2'h2, adr[1], 16'h0000);
		cmd(2'h1, adr[3], 16'($urandom));
		cmd(2'h2, adr[3], 16'h0000);
		cmd(2'h0, {2'h2, 4'($urandom)}, 16'h0000);
		cmd(2'h2, adr[3], 16'h0000);
		cmd(2'h2, 6'($urandom), 16'h0000);
		chk({15'h0, prog_en}, 16'h0001, "enable held");
		cmd(2'h0, {2'h0, 4'($urandom)}, 16'h0000);
		chk({15'h0, prog_en}, 16'h0000, "enable cleared");
		cmd(2'h1, adr[2], 16'h5a5a);
		cmd(2'h3, adr[2], 16'h0000);
		cmd(2'h0, {2'h1, 4'h0}, 16'h0f0f);
		cmd(2'h0, {2'h2, 4'h0}, 16'h0000);
		cmd(2'h2, adr[2], 16'h0000);
		results();
	end
endmodule
`default_nettype wire
